/* verilog/dcrl_cfg.svh */
`ifndef DCRL_CFG_SVH
`define DCRL_CFG_SVH
// register byte offsets
`define DCRL_OFF_SYS_CFG    8'h00
`define DCRL_OFF_LOCK_CODE  8'h04
`define DCRL_OFF_ANALOG_SEL 8'h08
`define DCRL_OFF_RELAY1_FN  8'h0C
`define DCRL_OFF_RELAY2_FN  8'h10
`define DCRL_OFF_AUX_FN     8'h14
`define DCRL_OFF_MIN_FREQ   8'h18
`define DCRL_OFF_UNLOCK     8'h1C
`define DCRL_OFF_STATUS     8'h20
`define DCRL_OFF_INT_STAT   8'h24
`define DCRL_OFF_INT_CLR    8'h28
`define DCRL_OFF_INT_EN     8'h2C
// limits and reset values
`define DCRL_SYS_CFG_MAX    8'h04
`define DCRL_LOCK_MAX       8'h63
`define DCRL_ANALOG_MAX     8'h03
`define DCRL_RELAY1_MAX     8'h06
`define DCRL_RELAY2_MAX     8'h05
`define DCRL_AUX_MAX        8'h02
`define DCRL_SYS_CFG_RST    3'h0
`define DCRL_LOCK_RST       7'h00
`define DCRL_ANALOG_RST     2'h0
`define DCRL_RELAY_RST      3'h0
`define DCRL_AUX_RST        2'h1
`define DCRL_MIN_FREQ_RST   16'h0000
// aux function field positions
`define DCRL_AUX_ONE_LSB    0
`define DCRL_AUX_TWO_LSB    8
// interrupt bit positions
`define DCRL_INT_REJECT     0
`define DCRL_INT_FAULT      1
`define DCRL_INT_RELAY      2
`define DCRL_INT_W          3
`endif

/* verilog/dcrl_pkg.sv */
package dcrl_pkg;
  typedef enum logic [2:0] {
    DCRL_CFG_AUX_RUN, DCRL_CFG_PRESSURE, DCRL_CFG_POT_SPEED,
    DCRL_CFG_CURRENT_SPEED, DCRL_CFG_HOA
  } dcrl_sys_cfg_t;
  typedef struct packed {
    logic       run;
    logic       pressure_loop;
    logic       hoa_active;
    logic [1:0] speed_source;   // 0 none, 1 pot, 2 current
  } dcrl_ctrl_t;
  typedef struct packed {
    logic primary_two;
    logic backup_used;
  } dcrl_analog_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dcrl_bus_req_t;
endpackage

/* verilog/dcrl_top.sv */
// Behaviour
// - configuration selector 0..4, reset 0, picks run and speed sources
// - config 0 runs only while both auxiliary inputs report run (contact closed, or aux function 1)
// - aux functions default to always-run so config 0 runs with no contacts
// - config 1 closes the pressure loop on the analog pressure input
// - config 2 speed from potentiometer, config 3 speed from current input
// - config 4 pressure from current input, honours hand-off-auto, pot speed
// - lock engaged: reads still work, every parameter write refused
// - lock code 0..99, reset 0; zero disables locking
// - analog select: 0 one, 1 two, 2 one backed by two, 3 two backed by one
// - relay function 0: closed normally, open on any system fault
// - relay functions 1..3 reserved; relay held open
// - relay function 4: closed normally, open on pump fault
// - relay function 5: closed while frequency exceeds minimum frequency
// - lead/lag control overrides relay two, and relay one unless it is on function 6
// - relay function 6: ignores lead/lag, closed while frequency above zero
// - function 6 only for relay one; relay two limited 0..5, reset 0
// - aux function 0 follows the contact, 1 is always run
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dcrl_cfg.svh"
module dcrl_top
  import dcrl_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // contacts and field pins
  input  wire logic        auxiliary_contact_one,
  input  wire logic        auxiliary_contact_two,
  input  wire logic [1:0]  hand_off_auto_switch,
  input  wire logic        current_one_ok,
  input  wire logic        current_two_ok,
  // drive status from same clock
  input  wire logic        system_fault,
  input  wire logic        pump_fault,
  input  wire logic [15:0] motor_freq,
  input  wire logic        lead_lag_active,
  input  wire logic        lead_lag_relay_one,
  input  wire logic        lead_lag_relay_two,
  // control outputs
  output logic             motor_run,
  output logic             pressure_loop,
  output logic             hoa_active,
  output logic [1:0]       speed_source,
  output logic             current_primary_two,
  output logic             current_backup_used,
  output logic             relay_one_open_contact,
  output logic             relay_two_open_contact,
  output logic             irq
);
  logic [2:0]  sys_cfg_q;
  logic [6:0]  lock_code_q;
  logic        locked_q;
  logic [1:0]  analog_sel_q;
  logic [2:0]  relay1_fn_q;
  logic [2:0]  relay2_fn_q;
  logic [1:0]  auxiliary_contact_one_fn_q;
  logic [1:0]  auxiliary_contact_two_fn_q;
  logic [15:0] min_freq_q;
  logic [1:0]  auxiliary_contact_one_s1_q, auxiliary_contact_one_s2_q;
  logic [1:0]  auxiliary_contact_two_s1_q, auxiliary_contact_two_s2_q;
  logic [1:0]  cur_s1_q,  cur_s2_q;
  logic [1:0]  hoa_s1_q,  hoa_s2_q;
  logic [`DCRL_INT_W-1:0] int_stat_q;
  logic [`DCRL_INT_W-1:0] int_en_q;
  logic [31:0] rdata_q;
  logic        relay1_q, relay2_q, irq_q;
  dcrl_ctrl_t   ctrl_q;
  dcrl_analog_t analog_q;
  dcrl_bus_req_t req;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // relay condition for one function code
  function automatic logic relay_cond(input logic [2:0] fn, input logic sf,
                                      input logic pf, input logic [15:0] fq,
                                      input logic [15:0] mf);
    unique case (fn)
      3'h0:    relay_cond = !sf;
      3'h4:    relay_cond = !pf;
      3'h5:    relay_cond = fq > mf;
      3'h6:    relay_cond = fq != 16'h0000;
      default: relay_cond = 1'b0;
    endcase
  endfunction

  // aux input decode
  function automatic logic aux_run(input logic [1:0] fn, input logic contact);
    aux_run = (fn == 2'h1) ? 1'b1 : contact;
  endfunction

  // write decode
  wire        wr_ok      = req.wr && !locked_q;
  wire [7:0]  wv         = req.wdata[7:0];
  wire        wr_cfg     = wr_ok && req.addr == `DCRL_OFF_SYS_CFG;
  wire        wr_lock    = wr_ok && req.addr == `DCRL_OFF_LOCK_CODE;
  wire        wr_analog  = wr_ok && req.addr == `DCRL_OFF_ANALOG_SEL;
  wire        wr_r1      = wr_ok && req.addr == `DCRL_OFF_RELAY1_FN;
  wire        wr_r2      = wr_ok && req.addr == `DCRL_OFF_RELAY2_FN;
  wire        wr_aux     = wr_ok && req.addr == `DCRL_OFF_AUX_FN;
  wire        wr_minf    = wr_ok && req.addr == `DCRL_OFF_MIN_FREQ;
  wire        wr_unlock  = req.wr && req.addr == `DCRL_OFF_UNLOCK;
  wire        wr_clr     = req.wr && req.addr == `DCRL_OFF_INT_CLR;
  wire        wr_en      = req.wr && req.addr == `DCRL_OFF_INT_EN;
  wire [7:0]  auxiliary_contact_one_v     = req.wdata[`DCRL_AUX_ONE_LSB +: 8];
  wire [7:0]  auxiliary_contact_two_v     = req.wdata[`DCRL_AUX_TWO_LSB +: 8];
  wire        cfg_good   = wv <= `DCRL_SYS_CFG_MAX;
  wire        lock_good  = wv <= `DCRL_LOCK_MAX;
  wire        an_good    = wv <= `DCRL_ANALOG_MAX;
  wire        r1_good    = wv <= `DCRL_RELAY1_MAX;
  wire        r2_good    = wv <= `DCRL_RELAY2_MAX;
  wire        aux_good   = auxiliary_contact_one_v <= `DCRL_AUX_MAX && auxiliary_contact_two_v <= `DCRL_AUX_MAX;
  wire        reject     = (wr_cfg && !cfg_good) || (wr_lock && !lock_good)
                        || (wr_analog && !an_good) || (wr_r1 && !r1_good)
                        || (wr_r2 && !r2_good) || (wr_aux && !aux_good)
                        || (req.wr && locked_q && !wr_unlock && !wr_clr && !wr_en);
  wire        unlock_hit = wr_unlock && wv[6:0] == lock_code_q && wv[7] == 1'b0;

  // control selection
  wire        auxiliary_contact_one_run   = aux_run(auxiliary_contact_one_fn_q, auxiliary_contact_one_s2_q[1]);
  wire        auxiliary_contact_two_run   = aux_run(auxiliary_contact_two_fn_q, auxiliary_contact_two_s2_q[1]);
  wire        hoa_run    = hoa_s2_q != 2'h1;
  dcrl_ctrl_t ctrl_d;
  always_comb begin
    ctrl_d = '0;
    unique case (dcrl_sys_cfg_t'(sys_cfg_q))
      DCRL_CFG_AUX_RUN:       ctrl_d.run = auxiliary_contact_one_run && auxiliary_contact_two_run;
      DCRL_CFG_PRESSURE: begin
        ctrl_d.run           = 1'b1;
        ctrl_d.pressure_loop = 1'b1;
      end
      DCRL_CFG_POT_SPEED: begin
        ctrl_d.run          = 1'b1;
        ctrl_d.speed_source = 2'h1;
      end
      DCRL_CFG_CURRENT_SPEED: begin
        ctrl_d.run          = 1'b1;
        ctrl_d.speed_source = 2'h2;
      end
      DCRL_CFG_HOA: begin
        ctrl_d.run           = hoa_run;
        ctrl_d.pressure_loop = 1'b1;
        ctrl_d.hoa_active    = 1'b1;
        ctrl_d.speed_source  = 2'h1;
      end
      default: ctrl_d = '0;
    endcase
  end

  // analog selection
  dcrl_analog_t analog_d;
  always_comb begin
    analog_d = '0;
    unique case (analog_sel_q)
      2'h0: analog_d.primary_two = 1'b0;
      2'h1: analog_d.primary_two = 1'b1;
      2'h2: analog_d.primary_two = !cur_s2_q[0] && cur_s2_q[1];
      2'h3: analog_d.primary_two = !(!cur_s2_q[1] && cur_s2_q[0]);
    endcase
    analog_d.backup_used = (analog_sel_q == 2'h2 && analog_d.primary_two)
                        || (analog_sel_q == 2'h3 && !analog_d.primary_two);
  end

  // relays; lead/lag overrides unless relay one is function 6
  wire r1_own  = relay_cond(relay1_fn_q, system_fault, pump_fault, motor_freq, min_freq_q);
  wire r2_own  = relay_cond(relay2_fn_q, system_fault, pump_fault, motor_freq, min_freq_q);
  wire relay1_d = (lead_lag_active && relay1_fn_q != 3'h6) ? lead_lag_relay_one : r1_own;
  wire relay2_d = lead_lag_active ? lead_lag_relay_two : r2_own;

  // events
  wire [`DCRL_INT_W-1:0] ev = {relay1_d != relay1_q, system_fault || pump_fault, reject};
  wire [`DCRL_INT_W-1:0] int_stat_d = ev | (int_stat_q & ~(wr_clr ? req.wdata[`DCRL_INT_W-1:0]
                                                         : '0));

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    unique case (req.addr)
      `DCRL_OFF_SYS_CFG:    rd_mux = {29'h0, sys_cfg_q};
      `DCRL_OFF_LOCK_CODE:  rd_mux = 32'h0; // code itself never readable
      `DCRL_OFF_ANALOG_SEL: rd_mux = {30'h0, analog_sel_q};
      `DCRL_OFF_RELAY1_FN:  rd_mux = {29'h0, relay1_fn_q};
      `DCRL_OFF_RELAY2_FN:  rd_mux = {29'h0, relay2_fn_q};
      `DCRL_OFF_AUX_FN:     rd_mux = {22'h0, auxiliary_contact_two_fn_q, 6'h0, auxiliary_contact_one_fn_q};
      `DCRL_OFF_MIN_FREQ:   rd_mux = {16'h0, min_freq_q};
      `DCRL_OFF_STATUS:     rd_mux = {22'h0, locked_q, relay2_q, relay1_q,
                                      analog_q, ctrl_q};
      `DCRL_OFF_INT_STAT:   rd_mux = {29'h0, int_stat_q};
      `DCRL_OFF_INT_EN:     rd_mux = {29'h0, int_en_q};
      default:              rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    auxiliary_contact_one_s1_q <= {auxiliary_contact_one_s1_q[0], auxiliary_contact_one};
    auxiliary_contact_one_s2_q <= {auxiliary_contact_one_s2_q[0], auxiliary_contact_one_s1_q[1]};
    auxiliary_contact_two_s1_q <= {auxiliary_contact_two_s1_q[0], auxiliary_contact_two};
    auxiliary_contact_two_s2_q <= {auxiliary_contact_two_s2_q[0], auxiliary_contact_two_s1_q[1]};
  end

  always_ff @(posedge clk) begin
    cur_s1_q <= {current_two_ok, current_one_ok};
    cur_s2_q <= cur_s1_q;
    hoa_s1_q <= hand_off_auto_switch;
    hoa_s2_q <= hoa_s1_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sys_cfg_q    <= `DCRL_SYS_CFG_RST;
      lock_code_q  <= `DCRL_LOCK_RST;
      analog_sel_q <= `DCRL_ANALOG_RST;
      relay1_fn_q  <= `DCRL_RELAY_RST;
      relay2_fn_q  <= `DCRL_RELAY_RST;
      auxiliary_contact_one_fn_q    <= `DCRL_AUX_RST;
      auxiliary_contact_two_fn_q    <= `DCRL_AUX_RST;
      min_freq_q   <= `DCRL_MIN_FREQ_RST;
    end else begin
      if (wr_cfg && cfg_good)     sys_cfg_q    <= wv[2:0];
      if (wr_lock && lock_good)   lock_code_q  <= wv[6:0];
      if (wr_analog && an_good)   analog_sel_q <= wv[1:0];
      if (wr_r1 && r1_good)       relay1_fn_q  <= wv[2:0];
      if (wr_r2 && r2_good)       relay2_fn_q  <= wv[2:0];
      if (wr_aux && aux_good) begin
        auxiliary_contact_one_fn_q <= auxiliary_contact_one_v[1:0];
        auxiliary_contact_two_fn_q <= auxiliary_contact_two_v[1:0];
      end
      if (wr_minf)                min_freq_q   <= req.wdata[15:0];
    end
  end

  // lock engages on any non-matching unlock write once code is nonzero; matching code releases
  always_ff @(posedge clk) begin
    if (reset)
      locked_q <= 1'b0;
    else if (lock_code_q == 7'h00)
      locked_q <= 1'b0;
    else if (wr_unlock)
      locked_q <= !unlock_hit;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q     <= '0;
      analog_q   <= '0;
      relay1_q   <= 1'b0;
      relay2_q   <= 1'b0;
      int_stat_q <= '0;
      int_en_q   <= '0;
      irq_q      <= 1'b0;
      rdata_q    <= 32'h0;
    end else begin
      ctrl_q     <= ctrl_d;
      analog_q   <= analog_d;
      relay1_q   <= relay1_d;
      relay2_q   <= relay2_d;
      int_stat_q <= int_stat_d;
      if (wr_en) int_en_q <= req.wdata[`DCRL_INT_W-1:0];
      irq_q      <= |(int_stat_d & (wr_en ? req.wdata[`DCRL_INT_W-1:0] : int_en_q));
      rdata_q    <= req.rd ? rd_mux : 32'h0;
    end
  end

  assign rdata                  = rdata_q;
  assign motor_run              = ctrl_q.run;
  assign pressure_loop          = ctrl_q.pressure_loop;
  assign hoa_active             = ctrl_q.hoa_active;
  assign speed_source           = ctrl_q.speed_source;
  assign current_primary_two    = analog_q.primary_two;
  assign current_backup_used    = analog_q.backup_used;
  assign relay_one_open_contact = relay1_q;
  assign relay_two_open_contact = relay2_q;
  assign irq                    = irq_q;

  // steps of the lock behaviour
  sequence wrong_unlock_s;
    wr_unlock && !unlock_hit && lock_code_q != 7'h00;
  endsequence
  sequence held_lock_s;
    !wr_unlock && lock_code_q != 7'h00;
  endsequence
  sequence cfg_attempt_s;
    req.wr && req.addr == `DCRL_OFF_SYS_CFG;
  endsequence
  sequence right_unlock_s;
    unlock_hit && lock_code_q != 7'h00;
  endsequence

  // assertions
  cfg_range_a: assert property (@(posedge clk) disable iff (reset)
    sys_cfg_q <= 3'h4)
    else $error("config out of range");
  cfg_write_a: assert property (@(posedge clk) disable iff (reset)
    (wr_cfg && cfg_good) |=> sys_cfg_q == $past(wv[2:0]))
    else $error("good config not stored");
  cfg_reject_a: assert property (@(posedge clk) disable iff (reset)
    (wr_cfg && !cfg_good) |=> $stable(sys_cfg_q))
    else $error("bad config stored");
  relay2_reject_a: assert property (@(posedge clk) disable iff (reset)
    (wr_r2 && !r2_good) |=> $stable(relay2_fn_q))
    else $error("bad relay two function stored");
  aux_reject_a: assert property (@(posedge clk) disable iff (reset)
    (wr_aux && !aux_good) |=> $stable(auxiliary_contact_one_fn_q) && $stable(auxiliary_contact_two_fn_q))
    else $error("bad aux function stored");
  reject_flag_a: assert property (@(posedge clk) disable iff (reset)
    reject |=> int_stat_q[`DCRL_INT_REJECT])
    else $error("rejected write not flagged");
  lock_write_a: assert property (@(posedge clk) disable iff (reset)
    (locked_q && req.wr && req.addr == `DCRL_OFF_SYS_CFG) |=> $stable(sys_cfg_q))
    else $error("write passed lock");
  lock_engage_a: assert property (@(posedge clk) disable iff (reset)
    wrong_unlock_s |=> locked_q)
    else $error("wrong code did not lock");
  lock_keep_a: assert property (@(posedge clk) disable iff (reset)
    wrong_unlock_s ##1 held_lock_s ##1 cfg_attempt_s |=> $stable(sys_cfg_q))
    else $error("lock released without code");
  read_locked_a: assert property (@(posedge clk) disable iff (reset)
    (locked_q && req.rd && req.addr == `DCRL_OFF_SYS_CFG)
    |=> rdata == {29'h0, $past(sys_cfg_q)})
    else $error("read blocked by lock");
  unlock_a: assert property (@(posedge clk) disable iff (reset)
    right_unlock_s |=> !locked_q)
    else $error("right code did not unlock");
  lock_zero_a: assert property (@(posedge clk) disable iff (reset)
    (lock_code_q == 7'h00) |=> !locked_q)
    else $error("lock with zero code");
  lock_range_a: assert property (@(posedge clk) disable iff (reset)
    lock_code_q <= 7'h63)
    else $error("lock code out of range");
  lock_keep_code_a: assert property (@(posedge clk) disable iff (reset)
    (wr_lock && !lock_good) |=> $stable(lock_code_q))
    else $error("bad lock code stored");
  aux_run_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h0 && auxiliary_contact_one_fn_q == 2'h0 && !auxiliary_contact_one_s2_q[1]) |=> !motor_run)
    else $error("ran with contact open");
  auxiliary_contact_two_run_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h0 && auxiliary_contact_two_fn_q == 2'h0 && !auxiliary_contact_two_s2_q[1]) |=> !motor_run)
    else $error("ran with contact two open");
  aux_free_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h0 && auxiliary_contact_one_fn_q == 2'h1 && auxiliary_contact_two_fn_q == 2'h1) |=> motor_run)
    else $error("always-run aux did not run");
  pressure_cfg_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h1) |=> pressure_loop && motor_run && speed_source == 2'h0)
    else $error("pressure config wrong");
  pot_speed_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h2) |=> speed_source == 2'h1 && !pressure_loop)
    else $error("pot speed config wrong");
  current_speed_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h3) |=> speed_source == 2'h2 && !pressure_loop)
    else $error("current speed config wrong");
  hoa_mode_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h4) |=> pressure_loop && hoa_active && speed_source == 2'h1)
    else $error("hand-off-auto config wrong");
  hoa_off_a: assert property (@(posedge clk) disable iff (reset)
    (sys_cfg_q == 3'h4 && hoa_s2_q == 2'h1) |=> !motor_run)
    else $error("ran with switch off");
  analog_one_a: assert property (@(posedge clk) disable iff (reset)
    (analog_sel_q == 2'h0) |=> !current_primary_two && !current_backup_used)
    else $error("input one select wrong");
  analog_two_a: assert property (@(posedge clk) disable iff (reset)
    (analog_sel_q == 2'h1) |=> current_primary_two && !current_backup_used)
    else $error("input two select wrong");
  analog_backup_a: assert property (@(posedge clk) disable iff (reset)
    (analog_sel_q == 2'h2 && !cur_s2_q[0] && cur_s2_q[1])
    |=> current_primary_two && current_backup_used)
    else $error("backup two not used");
  analog_spare_a: assert property (@(posedge clk) disable iff (reset)
    (analog_sel_q == 2'h3 && cur_s2_q[0] && !cur_s2_q[1])
    |=> !current_primary_two && current_backup_used)
    else $error("backup one not used");
  relay1_range_a: assert property (@(posedge clk) disable iff (reset)
    relay1_fn_q <= 3'h6)
    else $error("relay one function out of range");
  relay2_range_a: assert property (@(posedge clk) disable iff (reset)
    relay2_fn_q <= 3'h5)
    else $error("relay two function six");
  fault_relay_a: assert property (@(posedge clk) disable iff (reset)
    (relay1_fn_q == 3'h0 && !lead_lag_active && system_fault) |=> !relay_one_open_contact)
    else $error("relay closed on fault");
  fault_relay2_a: assert property (@(posedge clk) disable iff (reset)
    (relay2_fn_q == 3'h0 && !lead_lag_active && system_fault) |=> !relay_two_open_contact)
    else $error("relay two closed on fault");
  reserved_a: assert property (@(posedge clk) disable iff (reset)
    (relay2_fn_q inside {3'h1, 3'h2, 3'h3} && !lead_lag_active) |=> !relay_two_open_contact)
    else $error("reserved relay closed");
  reserved1_a: assert property (@(posedge clk) disable iff (reset)
    (relay1_fn_q inside {3'h1, 3'h2, 3'h3} && !lead_lag_active) |=> !relay_one_open_contact)
    else $error("reserved relay one closed");
  pump_relay_a: assert property (@(posedge clk) disable iff (reset)
    (relay1_fn_q == 3'h4 && !lead_lag_active && pump_fault) |=> !relay_one_open_contact)
    else $error("relay closed on pump fault");
  min_freq_a: assert property (@(posedge clk) disable iff (reset)
    (relay2_fn_q == 3'h5 && !lead_lag_active)
    |=> relay_two_open_contact == $past(motor_freq > min_freq_q))
    else $error("min frequency relay wrong");
  jockey_a: assert property (@(posedge clk) disable iff (reset)
    (relay1_fn_q == 3'h6) |=> relay_one_open_contact == ($past(motor_freq) != 16'h0000))
    else $error("jockey relay wrong");
  leadlag_a: assert property (@(posedge clk) disable iff (reset)
    lead_lag_active |=> relay_two_open_contact == $past(lead_lag_relay_two))
    else $error("lead lag not followed");
  leadlag1_a: assert property (@(posedge clk) disable iff (reset)
    (lead_lag_active && relay1_fn_q != 3'h6)
    |=> relay_one_open_contact == $past(lead_lag_relay_one))
    else $error("lead lag not followed on relay one");
endmodule
`default_nettype wire

/* verif/dcrl_field_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcrl_field_model (
  // commanded field state, changed by the bench just after an edge
  input  wire logic [10:0] cmd,
  input  wire logic [15:0] fcmd,
  // toward the drive logic
  output logic             auxiliary_contact_one,
  output logic             auxiliary_contact_two,
  output logic [1:0]       hand_off_auto_switch,
  output logic             current_one_ok,
  output logic             current_two_ok,
  output logic             system_fault,
  output logic             pump_fault,
  output logic             lead_lag_active,
  output logic             lead_lag_relay_one,
  output logic             lead_lag_relay_two,
  output logic [15:0]      motor_freq
);
  // contacts, sensors and drive status as plain levels
  assign {lead_lag_relay_two, lead_lag_relay_one, lead_lag_active, pump_fault,
          system_fault, current_two_ok, current_one_ok, hand_off_auto_switch,
          auxiliary_contact_two, auxiliary_contact_one} = cmd;
  assign motor_freq = fcmd;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcrl_cfg.svh"
module tb_top;
  import dcrl_pkg::*;
  logic clk, reset, wr, rd, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [10:0] cmd;
  logic [15:0] fcmd, motor_freq;
  logic auxiliary_contact_one, auxiliary_contact_two, current_one_ok, current_two_ok;
  logic system_fault, pump_fault, lead_lag_active, lead_lag_relay_one, lead_lag_relay_two;
  logic motor_run, pressure_loop, hoa_active, current_primary_two, current_backup_used;
  logic relay_one_open_contact, relay_two_open_contact;
  logic [1:0] hand_off_auto_switch, speed_source;
  int fails, num_checks, i, k, v;
  int regm[6];
  logic [7:0] offs[6];

  dcrl_field_model i_field (.cmd, .fcmd, .auxiliary_contact_one, .auxiliary_contact_two,
    .hand_off_auto_switch, .current_one_ok, .current_two_ok, .system_fault, .pump_fault,
    .lead_lag_active, .lead_lag_relay_one, .lead_lag_relay_two, .motor_freq);

  dcrl_top i_dut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .auxiliary_contact_one,
    .auxiliary_contact_two, .hand_off_auto_switch, .current_one_ok, .current_two_ok,
    .system_fault, .pump_fault, .motor_freq, .lead_lag_active, .lead_lag_relay_one,
    .lead_lag_relay_two, .motor_run, .pressure_loop, .hoa_active, .speed_source,
    .current_primary_two, .current_backup_used, .relay_one_open_contact,
    .relay_two_open_contact, .irq);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    finish_test;
  end

  task automatic chk(input logic [31:0] got, input int exp_v);
    num_checks++;
    if (got !== 32'(exp_v)) begin
      fails++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp_v);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input int v);
    @(posedge clk);
    addr <= a;
    wdata <= 32'(v);
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input int v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, v);
  endtask

  // relay level for one function code, 1 = closed
  function automatic int rly(input int fn);
    if (fn == 0) return !cmd[6];
    if (fn == 4) return !cmd[7];
    if (fn == 5) return int'(fcmd) > regm[5];
    if (fn == 6) return fcmd != 0;
    return 0;
  endfunction

  task automatic chk_out;
    int ca1, ca2, run, sp, p2, bk, r1, r2, sel;
    repeat (5) @(posedge clk);
    #1;
    ca1 = (regm[4] & 255) == 1 || cmd[0];
    ca2 = (regm[4] >> 8) == 1 || cmd[1];
    run = regm[0] == 0 ? ca1 && ca2 : regm[0] == 4 ? cmd[3:2] != 2'h1 : 1;
    sp = regm[0] == 2 || regm[0] == 4 ? 1 : regm[0] == 3 ? 2 : 0;
    sel = regm[1];
    bk = (sel == 2 && !cmd[4] && cmd[5]) || (sel == 3 && !cmd[5] && cmd[4]);
    p2 = sel == 1 || (sel == 2 && bk) || (sel == 3 && !bk);
    r1 = cmd[8] && regm[2] != 6 ? cmd[9] : rly(regm[2]);
    r2 = cmd[8] ? cmd[10] : rly(regm[3]);
    chk({motor_run, pressure_loop, hoa_active, speed_source, current_primary_two,
         current_backup_used, relay_one_open_contact, relay_two_open_contact},
        run << 8 | (regm[0] == 1 || regm[0] == 4) << 7 | (regm[0] == 4) << 6 | sp << 4
        | p2 << 3 | bk << 2 | r1 << 1 | r2);
  endtask

  function automatic bit legal(input int r, input int v);
    case (r)
      0: return v <= 4;
      1: return v <= 3;
      2: return v <= 6;
      3: return v <= 5;
      4: return (v & 255) <= 2 && (v >> 8) <= 2;
      default: return 1;
    endcase
  endfunction

  initial begin
    {reset, wr, rd, addr, wdata, cmd, fcmd} = '0;
    reset = 1'b1;
    regm = '{0, 0, 0, 0, 32'h0101, 0};
    offs = '{`DCRL_OFF_SYS_CFG, `DCRL_OFF_ANALOG_SEL, `DCRL_OFF_RELAY1_FN,
             `DCRL_OFF_RELAY2_FN, `DCRL_OFF_AUX_FN, `DCRL_OFF_MIN_FREQ};
    void'($urandom(32'h14BD));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (k = 0; k < 6; k++) rd_reg(offs[k], regm[k]);
    chk_out;
    rd_reg(8'h30, 0);
    wr_reg(`DCRL_OFF_RELAY2_FN, 6);
    rd_reg(`DCRL_OFF_RELAY2_FN, 0);
    for (i = 0; i < 300; i++) begin
      k = $urandom_range(0, 5);
      v = $urandom_range(0, 7) | (k == 4 ? $urandom_range(0, 3) << 8 : 0);
      @(posedge clk);
      cmd <= 11'($urandom);
      fcmd <= 16'($urandom_range(0, 7));
      wr_reg(offs[k], v);
      if (legal(k, v)) regm[k] = v;
      rd_reg(offs[k], regm[k]);
      chk_out;
    end
    // rejected-write interrupt: quiet field first, then raise, mask, clear
    @(posedge clk);
    cmd <= '0;
    wr_reg(`DCRL_OFF_INT_CLR, 7);
    wr_reg(`DCRL_OFF_INT_EN, 1);
    wr_reg(`DCRL_OFF_SYS_CFG, 5);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1);
    rd_reg(`DCRL_OFF_INT_STAT, 1);
    wr_reg(`DCRL_OFF_INT_EN, 0);
    repeat (2) @(posedge clk);
    #1 chk(irq, 0);
    wr_reg(`DCRL_OFF_INT_CLR, 1);
    wr_reg(`DCRL_OFF_INT_EN, 1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 0);
    // lock code, wrong and right unlock values
    wr_reg(`DCRL_OFF_LOCK_CODE, 42);
    wr_reg(`DCRL_OFF_LOCK_CODE, 100);
    wr_reg(`DCRL_OFF_UNLOCK, 5);
    wr_reg(`DCRL_OFF_SYS_CFG, regm[0] ^ 1);
    rd_reg(`DCRL_OFF_SYS_CFG, regm[0]);
    wr_reg(`DCRL_OFF_UNLOCK, 42);
    regm[0] = 2;
    wr_reg(`DCRL_OFF_SYS_CFG, 2);
    rd_reg(`DCRL_OFF_SYS_CFG, 2);
    wr_reg(`DCRL_OFF_LOCK_CODE, 0);
    wr_reg(`DCRL_OFF_UNLOCK, 5);
    regm[0] = 3;
    wr_reg(`DCRL_OFF_SYS_CFG, 3);
    rd_reg(`DCRL_OFF_SYS_CFG, 3);
    chk_out;
    finish_test;
  end
endmodule
`default_nettype wire
